//--- logic/pic_top.sv
// peripheral interrupt controller with AXI4-Lite register slave
`timescale 1ns/1ps
module pic_top
   import pic_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // peripheral sources
   input wire pic_events_t EVENTS,
   input wire pic_ccp_mode_t CCP_MODE,
   input wire logic RX_BUFFER_FULL,
   input wire logic TX_BUFFER_EMPTY,
   input wire logic [2:0] EXT_PINS,
   input wire logic [3:0] PORT_B_HIGH,
   input wire logic PORT_B_READ,
   input wire logic [4:0] RESET_CAUSE_SET,
   // processor core
   input wire logic CORE_SLEEPING,
   input wire logic INT_ACK,
   input wire logic RETURN_FROM_INT,
   input wire pic_context_t CORE_CONTEXT,
   output logic WAKE,
   output logic INT_REQ,
   output logic [20:0] INT_VECTOR,
   output pic_context_t SAVED_CONTEXT
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [7:0] flags_one_q, flags_two_q, en_one_q, en_two_q, pr_one_q, pr_two_q;
   logic [7:0] rctrl_q, ctrl_one_q, ctrl_two_q, ctrl_three_q;
   logic [2:0] pin_q;
   logic [3:0] portb_q;
   logic req_high_q, req_low_q, in_high_q, in_low_q;
   logic [20:0] vector_q;
   pic_context_t ctx_q;

   // ------------------------------------------------------------
   // AXI4-Lite write path: address and data accepted in either order
   // ------------------------------------------------------------
   logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q, araddr_wire;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic rresp_err_q, bresp_err_q;
   wire aw_take = S_AXI_AWVALID && !aw_held_q && !bvalid_q;
   wire w_take = S_AXI_WVALID && !w_held_q && !bvalid_q;
   wire aw_have = aw_held_q || aw_take;
   wire w_have = w_held_q || w_take;
   wire wr_fire = aw_have && w_have && !bvalid_q;
   wire [7:0] wr_addr = aw_held_q ? awaddr_q : S_AXI_AWADDR;
   wire [31:0] wr_data = w_held_q ? wdata_q : S_AXI_WDATA;
   wire [3:0] wr_strb = w_held_q ? wstrb_q : S_AXI_WSTRB;
   wire wr_lane0 = wr_fire && wr_strb[0];
   wire [7:0] wd = wr_data[7:0];
   assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
   assign S_AXI_WREADY = !w_held_q && !bvalid_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_err_q ? 2'b10 : 2'b00;

   // address hit helper, shared by read and write decoders
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // write decode
   wire w_f1 = wr_lane0 && hit(wr_addr, OFS_FLAGS_ONE);
   wire w_f2 = wr_lane0 && hit(wr_addr, OFS_FLAGS_TWO);
   wire w_e1 = wr_lane0 && hit(wr_addr, OFS_ENABLES_ONE);
   wire w_e2 = wr_lane0 && hit(wr_addr, OFS_ENABLES_TWO);
   wire w_p1 = wr_lane0 && hit(wr_addr, OFS_PRIORITY_ONE);
   wire w_p2 = wr_lane0 && hit(wr_addr, OFS_PRIORITY_TWO);
   wire w_rc = wr_lane0 && hit(wr_addr, OFS_RESET_CTRL);
   wire w_c1 = wr_lane0 && hit(wr_addr, OFS_CTRL_ONE);
   wire w_c2 = wr_lane0 && hit(wr_addr, OFS_CTRL_TWO);
   wire w_c3 = wr_lane0 && hit(wr_addr, OFS_CTRL_THREE);
   wire wr_mapped = (wr_addr[1:0] == 2'b00) && (wr_addr <= OFS_CONTEXT_SHADOW);

   // write channel holding registers and response
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_err_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (aw_take && !wr_fire)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (w_take && !wr_fire)
         begin
            w_held_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_err_q <= !wr_mapped;
         end
         else if (S_AXI_BREADY)
            bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------
   // pin edge select: one means rising, zero falling
   wire [2:0] edge_sel = {ctrl_two_q[BIT_EDGE2], ctrl_two_q[BIT_EDGE1], ctrl_two_q[BIT_EDGE0]};
   wire [2:0] pin_edge = (EXT_PINS & ~pin_q & edge_sel) | (~EXT_PINS & pin_q & ~edge_sel);
   // a mismatch keeps setting the flag until the port is read, as on the real port
   wire portb_change = (PORT_B_HIGH != portb_q);
   wire capcmp_ev = (CCP_MODE == CCP_CAPTURE && EVENTS.capture)
                 || (CCP_MODE == CCP_COMPARE && EVENTS.compare);
   wire t0_ev = EVENTS.timer_zero_wrap8 || EVENTS.timer_zero_wrap16;
   wire [7:0] set_one = {1'b0, EVENTS.adc_done, 2'b00, 1'b0, capcmp_ev,
                         EVENTS.timer_two_match, EVENTS.timer_one_overflow};
   wire [7:0] set_two = {EVENTS.clock_failure, 2'b00, EVENTS.nvm_write_done, 1'b0,
                         EVENTS.low_supply, EVENTS.timer_three_overflow, 1'b0};

   // sticky flag update: set beats a software clear in the same cycle
   function automatic logic [7:0] sticky(input logic [7:0] cur, input logic wr, input logic [7:0] wv,
                                         input logic [7:0] set, input logic [7:0] mask);
      sticky = (((wr ? wv : cur) | set) & mask);
   endfunction

   // live status bits read straight from the serial unit
   wire [7:0] flags_one_view = (flags_one_q & MASK_SW_ONE)
                             | ({7'h00, RX_BUFFER_FULL} << BIT_RX)
                             | ({7'h00, TX_BUFFER_EMPTY} << BIT_TX);

   // ------------------------------------------------------------
   // request formation
   // ------------------------------------------------------------
   wire prio_mode = rctrl_q[BIT_PRIO_MODE];
   wire glb_h = ctrl_one_q[BIT_GLB_HIGH];
   wire glb_l = ctrl_one_q[BIT_GLB_LOW];
   wire [7:0] act_one = flags_one_view & en_one_q;
   wire [7:0] act_two = flags_two_q & en_two_q;
   wire t0_act = ctrl_one_q[BIT_T0_FLAG] && ctrl_one_q[BIT_T0_EN];
   wire p0_act = ctrl_one_q[BIT_P0_FLAG] && ctrl_one_q[BIT_P0_EN];
   wire pc_act = ctrl_one_q[BIT_PC_FLAG] && ctrl_one_q[BIT_PC_EN];
   wire p1_act = ctrl_three_q[BIT_P1_FLAG] && ctrl_three_q[BIT_P1_EN];
   wire p2_act = ctrl_three_q[BIT_P2_FLAG] && ctrl_three_q[BIT_P2_EN];
   // priority bits split each active source into a level, except pin zero, which always requests at high level
   wire periph_hi = |(act_one & pr_one_q) || |(act_two & pr_two_q);
   wire periph_lo = |(act_one & ~pr_one_q) || |(act_two & ~pr_two_q);
   wire core_hi = p0_act
               || (t0_act && ctrl_two_q[BIT_T0_PRIO]) || (pc_act && ctrl_two_q[BIT_PC_PRIO])
               || (p1_act && ctrl_three_q[BIT_P1_PRIO]) || (p2_act && ctrl_three_q[BIT_P2_PRIO]);
   wire core_lo = (t0_act && !ctrl_two_q[BIT_T0_PRIO]) || (pc_act && !ctrl_two_q[BIT_PC_PRIO])
               || (p1_act && !ctrl_three_q[BIT_P1_PRIO]) || (p2_act && !ctrl_three_q[BIT_P2_PRIO]);
   wire any_periph = |act_one || |act_two;
   wire any_core = t0_act || p0_act || pc_act || p1_act || p2_act;
   // single mode: bit 7 global, bit 6 peripheral group
   wire single_req = glb_h && (any_core || (glb_l && any_periph));
   // low level never preempts a running high routine
   wire high_req = glb_h && (core_hi || periph_hi);
   wire low_req = glb_l && (core_lo || periph_lo) && !in_high_q;
   wire req_high_d = prio_mode ? high_req : single_req;
   wire req_low_d = prio_mode && low_req && !high_req;
   wire take = INT_ACK && (req_high_q || req_low_q);
   wire wake_d = CORE_SLEEPING && (any_core || any_periph);

   // ------------------------------------------------------------
   // control and flag registers
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         flags_one_q <= RST_FLAGS;
         flags_two_q <= RST_FLAGS;
         en_one_q <= RST_ENABLES;
         en_two_q <= RST_ENABLES;
         pr_one_q <= RST_PRIORITY_ONE;
         pr_two_q <= RST_PRIORITY_TWO;
         rctrl_q <= RST_RESET_CTRL;
         ctrl_one_q <= RST_CTRL_ONE;
         ctrl_two_q <= RST_CTRL_TWO;
         ctrl_three_q <= RST_CTRL_THREE;
      end
      else
      begin
         flags_one_q <= sticky(flags_one_q, w_f1, wd, set_one, MASK_SW_ONE);
         flags_two_q <= sticky(flags_two_q, w_f2, wd, set_two, MASK_TWO);
         if (w_e1) en_one_q <= wd & MASK_ONE;
         if (w_e2) en_two_q <= wd & MASK_TWO;
         if (w_p1) pr_one_q <= wd & MASK_ONE;
         if (w_p2) pr_two_q <= wd & MASK_TWO;
         // cause bits: hardware sets win over software writes
         rctrl_q <= ((w_rc ? ((wd & MASK_RCTRL_RW) | (rctrl_q & ~MASK_RCTRL_RW)) : rctrl_q)
                     | {3'b000, RESET_CAUSE_SET});
         ctrl_one_q <= sticky(ctrl_one_q, w_c1, wd,
                              {2'b00, 3'b000, t0_ev, pin_edge[0], portb_change}, 8'hFF)
                       & ~({7'h00, take && (!prio_mode || req_high_q)} << BIT_GLB_HIGH)
                       & ~({7'h00, take && prio_mode && req_low_q && !req_high_q} << BIT_GLB_LOW)
                       | ({7'h00, RETURN_FROM_INT && (!prio_mode || in_high_q)} << BIT_GLB_HIGH)
                       | ({7'h00, RETURN_FROM_INT && prio_mode && !in_high_q && in_low_q} << BIT_GLB_LOW);
         if (w_c2) ctrl_two_q <= wd & MASK_CTRL_TWO;
         ctrl_three_q <= sticky(ctrl_three_q, w_c3, wd,
                                {6'h00, pin_edge[2], pin_edge[1]}, MASK_CTRL_THREE);
      end
   end

   // ------------------------------------------------------------
   // sampling, request, vector and context
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         pin_q <= 3'b000;
         portb_q <= 4'h0;
         req_high_q <= 1'b0;
         req_low_q <= 1'b0;
         in_high_q <= 1'b0;
         in_low_q <= 1'b0;
         vector_q <= VEC_HIGH;
         ctx_q <= '0;
         WAKE <= 1'b0;
      end
      else
      begin
         pin_q <= EXT_PINS;
         if (PORT_B_READ) portb_q <= PORT_B_HIGH; // reading ends the mismatch
         req_high_q <= req_high_d && !take;
         req_low_q <= req_low_d && !take;
         WAKE <= wake_d;
         vector_q <= (req_low_d && !req_high_d) ? VEC_LOW : VEC_HIGH;
         if (take)
         begin
            ctx_q <= CORE_CONTEXT;
            if (req_high_q) in_high_q <= 1'b1;
            else in_low_q <= 1'b1;
         end
         else if (RETURN_FROM_INT)
         begin
            if (in_high_q) in_high_q <= 1'b0;
            else in_low_q <= 1'b0;
         end
      end
   end
   assign INT_REQ = req_high_q || req_low_q;
   assign INT_VECTOR = vector_q;
   assign SAVED_CONTEXT = ctx_q;

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   assign araddr_wire = S_AXI_ARADDR;
   wire ar_take = S_AXI_ARVALID && !rvalid_q;
   wire [31:0] rd_mux =
      hit(araddr_wire, OFS_FLAGS_ONE) ? {24'h00_0000, flags_one_view} :
      hit(araddr_wire, OFS_FLAGS_TWO) ? {24'h00_0000, flags_two_q} :
      hit(araddr_wire, OFS_ENABLES_ONE) ? {24'h00_0000, en_one_q} :
      hit(araddr_wire, OFS_ENABLES_TWO) ? {24'h00_0000, en_two_q} :
      hit(araddr_wire, OFS_PRIORITY_ONE) ? {24'h00_0000, pr_one_q} :
      hit(araddr_wire, OFS_PRIORITY_TWO) ? {24'h00_0000, pr_two_q} :
      hit(araddr_wire, OFS_RESET_CTRL) ? {24'h00_0000, rctrl_q} :
      hit(araddr_wire, OFS_CTRL_ONE) ? {24'h00_0000, ctrl_one_q} :
      hit(araddr_wire, OFS_CTRL_TWO) ? {24'h00_0000, ctrl_two_q} :
      hit(araddr_wire, OFS_CTRL_THREE) ? {24'h00_0000, ctrl_three_q} :
      hit(araddr_wire, OFS_CONTEXT_PC) ? {11'h000, ctx_q.return_pc} :
      hit(araddr_wire, OFS_CONTEXT_SHADOW) ? {8'h00, ctx_q.working_accumulator, ctx_q.status,
                                              ctx_q.bank_select_register} :
      32'h0000_0000;
   wire rd_mapped = (araddr_wire[1:0] == 2'b00) && (araddr_wire <= OFS_CONTEXT_SHADOW);
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_err_q ? 2'b10 : 2'b00;

   // read data latch; unmapped addresses answer SLVERR with zero data
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_err_q <= 1'b0;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_err_q <= !rd_mapped;
      end
      else if (S_AXI_RREADY)
         rvalid_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_sticky_hold;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (flags_two_q[BIT_LVD] && !w_f2) |=> flags_two_q[BIT_LVD];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("flag lost without write");
   property p_flag_set;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      EVENTS.adc_done |=> flags_one_q[BIT_ADC];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("adc flag not set");
   property p_pwm_unused;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (CCP_MODE == CCP_PWM && !flags_one_q[BIT_CAPCMP] && !w_f1) |=> !flags_one_q[BIT_CAPCMP];
   endproperty
   a_pwm_unused: assert property (p_pwm_unused) else $error("capcmp set in pwm");
   property p_pin_flag;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (EXT_PINS[0] && !pin_q[0] && ctrl_two_q[BIT_EDGE0]) |=> ctrl_one_q[BIT_P0_FLAG];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("rising pin edge missed");
   property p_vector;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (INT_REQ && !prio_mode) |-> INT_VECTOR == VEC_HIGH;
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector in single mode");
   property p_glb_clear;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (take && !prio_mode && !RETURN_FROM_INT) |=> !ctrl_one_q[BIT_GLB_HIGH];
   endproperty
   a_glb_clear: assert property (p_glb_clear) else $error("global enable not cleared");
   property p_latency;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (p0_act && glb_h && !INT_ACK && !w_c1 && !RETURN_FROM_INT) ##1 !INT_ACK |-> INT_REQ;
   endproperty
   a_latency: assert property (p_latency) else $error("request late");
   property p_context;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      take |=> SAVED_CONTEXT == $past(CORE_CONTEXT);
   endproperty
   a_context: assert property (p_context) else $error("context not saved");
   property p_prio_reset;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(RESET_N) |-> !prio_mode;
   endproperty
   a_prio_reset: assert property (p_prio_reset) else $error("priority mode set at reset");
   c_high: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) take && req_high_q && prio_mode);
   c_low: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) take && req_low_q);
   c_wake: cover property (@(posedge SYS_CLK) disable iff (!RESET_N) WAKE);
endmodule // pic_top

//--- logic/pic_pkg.sv
// package for the peripheral interrupt controller: register map, fields, reset values, carriers
package pic_pkg;
   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_FLAGS_ONE = 8'h00;
   localparam logic [7:0] OFS_FLAGS_TWO = 8'h04;
   localparam logic [7:0] OFS_ENABLES_ONE = 8'h08;
   localparam logic [7:0] OFS_ENABLES_TWO = 8'h0C;
   localparam logic [7:0] OFS_PRIORITY_ONE = 8'h10;
   localparam logic [7:0] OFS_PRIORITY_TWO = 8'h14;
   localparam logic [7:0] OFS_RESET_CTRL = 8'h18;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h1C;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h20;
   localparam logic [7:0] OFS_CTRL_THREE = 8'h24;
   localparam logic [7:0] OFS_CONTEXT_PC = 8'h28;
   localparam logic [7:0] OFS_CONTEXT_SHADOW = 8'h2C;
   // implemented-bit masks
   localparam logic [7:0] MASK_ONE = 8'h77;
   localparam logic [7:0] MASK_TWO = 8'h96;
   localparam logic [7:0] MASK_SW_ONE = 8'h47;
   localparam logic [7:0] MASK_RCTRL_RW = 8'h93;
   localparam logic [7:0] MASK_CTRL_TWO = 8'h75;
   localparam logic [7:0] MASK_CTRL_THREE = 8'hDB;
   // field positions
   localparam int BIT_ADC = 6;
   localparam int BIT_RX = 5;
   localparam int BIT_TX = 4;
   localparam int BIT_CAPCMP = 2;
   localparam int BIT_TMR2 = 1;
   localparam int BIT_TMR1 = 0;
   localparam int BIT_OSCF = 7;
   localparam int BIT_NVM = 4;
   localparam int BIT_LVD = 2;
   localparam int BIT_TMR3 = 1;
   localparam int BIT_PRIO_MODE = 7;
   localparam int BIT_GLB_HIGH = 7;
   localparam int BIT_GLB_LOW = 6;
   localparam int BIT_T0_EN = 5;
   localparam int BIT_P0_EN = 4;
   localparam int BIT_PC_EN = 3;
   localparam int BIT_T0_FLAG = 2;
   localparam int BIT_P0_FLAG = 1;
   localparam int BIT_PC_FLAG = 0;
   localparam int BIT_T0_PRIO = 2;
   localparam int BIT_PC_PRIO = 0;
   localparam int BIT_EDGE0 = 6;
   localparam int BIT_EDGE1 = 5;
   localparam int BIT_EDGE2 = 4;
   localparam int BIT_P2_PRIO = 7;
   localparam int BIT_P1_PRIO = 6;
   localparam int BIT_P2_EN = 4;
   localparam int BIT_P1_EN = 3;
   localparam int BIT_P2_FLAG = 1;
   localparam int BIT_P1_FLAG = 0;
   // reset values
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_PRIORITY_ONE = 8'h77;
   localparam logic [7:0] RST_PRIORITY_TWO = 8'h96;
   localparam logic [7:0] RST_RESET_CTRL = 8'h1C;
   localparam logic [7:0] RST_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'hF5;
   localparam logic [7:0] RST_CTRL_THREE = 8'hC0;
   // vectors
   localparam logic [20:0] VEC_HIGH = 21'h00_0008;
   localparam logic [20:0] VEC_LOW = 21'h00_0018;
   // peripheral event strobes, one cycle each
   typedef struct packed {
      logic adc_done;
      logic capture;
      logic compare;
      logic timer_two_match;
      logic timer_one_overflow;
      logic clock_failure;
      logic nvm_write_done;
      logic low_supply;
      logic timer_three_overflow;
      logic timer_zero_wrap8;
      logic timer_zero_wrap16;
   } pic_events_t;
   // core context presented at interrupt entry
   typedef struct packed {
      logic [20:0] return_pc;
      logic [7:0] working_accumulator;
      logic [7:0] status;
      logic [7:0] bank_select_register;
   } pic_context_t;
   typedef enum logic [1:0] {
      CCP_CAPTURE,
      CCP_COMPARE,
      CCP_PWM
   } pic_ccp_mode_t;
endpackage

//--- sim/pic_core_model.sv
// core-side partner: takes interrupt requests and offers a fixed context
`timescale 1ns/1ps
module pic_core_model
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   output logic ack,
   output pic_context_t ctx
);
   // fixed, distinct context so a saved copy can be compared bit by bit
   assign ctx = {21'h01_2345, 8'hA5, 8'h3C, 8'h0F};
   // one-cycle ack after a request; never twice in a row, so a late drop is not acked again
   always_ff @(posedge clk)
   begin
      ack <= rst_n & req & ~ack;
   end
endmodule // pic_core_model

//--- sim/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
   import pic_pkg::*;
   logic c = 0, rn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, rx = 0, tx = 0, pbr = 0, slp = 0, ret = 0;
   logic awr, wrdy, bv, arr, rv, ack, req, wake;
   logic [7:0] aw = 0, ar = 0;
   logic [31:0] wd = 0, rd;
   logic [1:0] bresp, rresp;
   logic [2:0] pins = 0;
   logic [3:0] pb = 0;
   logic [4:0] rcs = 0;
   logic [20:0] vec;
   pic_events_t ev = '0;
   pic_ccp_mode_t ccp = CCP_CAPTURE;
   pic_context_t cctx, sctx;
   int err_total = 0, num_checks = 0;
   // 200 MHz system clock
   always #2.5 c = ~c;
   pic_top uut (.SYS_CLK(c), .RESET_N(rn), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .EVENTS(ev),
      .CCP_MODE(ccp), .RX_BUFFER_FULL(rx), .TX_BUFFER_EMPTY(tx), .EXT_PINS(pins), .PORT_B_HIGH(pb),
      .PORT_B_READ(pbr), .RESET_CAUSE_SET(rcs), .CORE_SLEEPING(slp), .INT_ACK(ack), .RETURN_FROM_INT(ret),
      .CORE_CONTEXT(cctx), .WAKE(wake), .INT_REQ(req), .INT_VECTOR(vec), .SAVED_CONTEXT(sctx));
   pic_core_model core (.clk(c), .rst_n(rn), .req(req), .ack(ack), .ctx(cctx));
   // ------------------------------------------------
   // bus tasks and compare
   // ------------------------------------------------
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ta, tw;
      @(posedge c);
      aw <= a;
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      br <= 1;
      do
      begin
         @(negedge c);
         ta = awv & awr;
         tw = wv & wrdy;
         @(posedge c);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
      end while (awv & ~ta | wv & ~tw);
      do @(negedge c); while (!bv);
      @(posedge c);
      br <= 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge c);
      ar <= a;
      arv <= 1;
      rr <= 1;
      do @(negedge c); while (!arr);
      @(posedge c);
      arv <= 0;
      do @(negedge c); while (!rv);
      @(posedge c);
      rr <= 0;
      chk({32'h0, rd}, {56'h0, e});
      chk({62'h0, rresp}, {62'h0, er});
   endtask
   task automatic ev_p(input logic [10:0] e);
      @(posedge c);
      ev <= e;
      @(posedge c);
      ev <= '0;
   endtask
   // waits for a request, checks its vector, lets the core take it
   task automatic take(input logic [20:0] v);
      repeat (20) if (req !== 1'b1) @(negedge c);
      chk({63'h0, req}, 64'h1);
      chk({43'h0, vec}, {43'h0, v});
      repeat (3) @(negedge c);
      chk({63'h0, req}, 64'h0);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: the whole sequence needs well under a thousand cycles
   initial
   begin
      #20000;
      err_total++;
      summarize;
   end
   initial
   begin
      repeat (2) @(posedge c);
      rn <= 1;
      rdc(OFS_ENABLES_ONE, 8'h00, 2'b00);
      rdc(OFS_PRIORITY_ONE, 8'h77, 2'b00);
      rdc(OFS_PRIORITY_TWO, 8'h96, 2'b00);
      rdc(OFS_RESET_CTRL, 8'h1C, 2'b00);
      rdc(8'h30, 8'h00, 2'b10);
      $display("reset values done");
      ev_p(11'h6C0);
      rdc(OFS_FLAGS_ONE, 8'h47, 2'b00);
      ev_p(11'h03C);
      rdc(OFS_FLAGS_TWO, 8'h96, 2'b00);
      wr(OFS_FLAGS_ONE, 8'h00);
      rdc(OFS_FLAGS_ONE, 8'h00, 2'b00);
      // capture and compare strobes only count in their own mode
      ccp <= CCP_PWM;
      ev_p(11'h300);
      ccp <= CCP_COMPARE;
      ev_p(11'h200);
      rdc(OFS_FLAGS_ONE, 8'h00, 2'b00);
      ev_p(11'h100);
      @(posedge c);
      rx <= 1;
      tx <= 1;
      rdc(OFS_FLAGS_ONE, 8'h34, 2'b00);
      rx <= 0;
      tx <= 0;
      $display("flag tests done");
      wr(OFS_ENABLES_ONE, 8'h40);
      wr(OFS_CTRL_ONE, 8'hC0);
      ev_p(11'h400);
      take(VEC_HIGH);
      chk({19'h0, sctx}, {19'h0, cctx});
      rdc(OFS_CTRL_ONE, 8'h40, 2'b00);
      // service done: clear the flag, then return so the routine is no longer marked active
      wr(OFS_FLAGS_ONE, 8'h00);
      ret <= 1;
      @(posedge c);
      ret <= 0;
      rdc(OFS_CTRL_ONE, 8'hC0, 2'b00);
      wr(OFS_RESET_CTRL, 8'h80);
      rcs <= 5'h03;
      @(posedge c);
      rcs <= 5'h00;
      rdc(OFS_RESET_CTRL, 8'h8F, 2'b00);
      wr(OFS_PRIORITY_ONE, 8'h37);
      ev_p(11'h400);
      take(VEC_LOW);
      rdc(OFS_CTRL_ONE, 8'h80, 2'b00);
      $display("vector tests done");
      @(posedge c);
      pins <= 3'b011;
      pb <= 4'h1;
      ev_p(11'h002);
      rdc(OFS_CTRL_ONE, 8'h87, 2'b00);
      rdc(OFS_CTRL_THREE, 8'hC1, 2'b00);
      $display("pin tests done");
      // port read ends the mismatch; pin zero then requests at high level
      slp <= 1;
      pbr <= 1;
      @(posedge c);
      pbr <= 0;
      wr(OFS_CTRL_ONE, 8'h92);
      take(VEC_HIGH);
      rdc(OFS_CTRL_ONE, 8'h12, 2'b00);
      chk({63'h0, wake}, 64'h1);
      $display("wake tests done");
      summarize;
   end
endmodule // testbench
